// ==== hw/brownout_and_reset_flags.sv ====
// brownout qualifier, threshold key check, reset cause flags and core reset
// assumes supply comparator and watchdog pulses are asynchronous to the clock
//
// Design decisions made here: the register addresses and the APB register port.
module brownout_and_reset_flags #(
	parameter int QUALIFY_CNT = brownout_pkg::QUALIFY_CYCLES,
	parameter int SRESET_CNT  = brownout_pkg::SRESET_CYCLES
) (
	input  wire logic                      ref_clk_i,
	input  wire logic                      srst_i,
	input  wire logic                      clk_en_i,
	input  wire logic                      brownout_enable_i,
	input  wire logic                      low_supply_i,
	input  wire logic                      wdt_expiry_i,
	input  wire logic                      wdt_key_reset_i,
	input  wire logic                      rst_key_reset_i,
	input  wire logic                      deep_sleep_i,
	input  wire brownout_pkg::power_mode_t power_mode_i,
	input  wire logic                      psel_i,
	input  wire logic                      penable_i,
	input  wire logic                      pwrite_i,
	input  wire logic [11:0]               paddr_i,
	input  wire logic [31:0]               pwdata_i,
	output logic      [31:0]               prdata_o,
	output logic                           pready_o,
	output logic                           pslverr_o,
	output brownout_pkg::core_reset_t      core_reset_o,
	output logic                           irq_o
);
	import brownout_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic key_valid(input logic [7:0] k);
		return (k == KEY_VALID_A) || (k == KEY_VALID_B) ||
			(k == KEY_VALID_C) || (k == KEY_VALID_D);
	endfunction

	function automatic logic low_power(input power_mode_t m,
		input logic ds);
		return ds || (m == MODE_IDLE) || (m == MODE_SLEEP);
	endfunction

	// set wins over a software clear in the same cycle
	function automatic logic [3:0] sticky(input logic [3:0] cur,
		input logic [3:0] keep, input logic [3:0] ev);
		return (cur & keep) | ev;
	endfunction

	// ****************************************
	// input synchronisers
	// ****************************************
	// two flops on the supply and expiry pins from outside the clock domain
	logic low_meta;
	logic low_sync;
	logic wdt_meta;
	logic wdt_sync;
	logic low_s;
	logic wdt_s;
	logic wdt_d;
	logic wdk_s;
	logic wdk_d;
	logic rsk_s;
	logic rsk_d;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			low_meta <= 1'b0;
			low_sync <= 1'b0;
			wdt_meta <= 1'b0;
			wdt_sync <= 1'b0;
		end else if (clk_en_i) begin
			low_meta <= low_supply_i;
			low_sync <= low_meta;
			wdt_meta <= wdt_expiry_i;
			wdt_sync <= wdt_meta;
		end
	end

	// third stage for supply and expiry, first stage for both key pulses: registered copies for the counters and detectors
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			low_s <= 1'b0;
			wdt_s <= 1'b0;
			wdk_s <= 1'b0;
			rsk_s <= 1'b0;
		end else if (clk_en_i) begin
			low_s <= low_sync;
			wdt_s <= wdt_sync;
			wdk_s <= wdt_key_reset_i;
			rsk_s <= rst_key_reset_i;
		end
	end

	// expiry, key and reset-key pulses: one more stage then edge detect
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			{wdt_d, wdk_d, rsk_d} <= 3'h0;
		end else if (clk_en_i) begin
			{wdt_d, wdk_d, rsk_d} <= {wdt_s, wdk_s, rsk_s};
		end
	end

	logic wdt_rise;
	logic wdk_rise;
	logic rsk_rise;
	assign wdt_rise = wdt_s & ~wdt_d;
	assign wdk_rise = wdk_s & ~wdk_d;
	assign rsk_rise = rsk_s & ~rsk_d;

	// ****************************************
	// registers and apb
	// ****************************************
	logic [7:0]            select_key;
	logic [CAUSE_BITS-1:0] reset_cause_flags;
	logic                  watchdog_expiry_flag;
	logic                  powerdown_flag;
	logic [IRQ_BITS-1:0]   irq_stat;
	logic [IRQ_BITS-1:0]   irq_mask;
	logic                  apb_setup;
	logic                  apb_wr;
	logic                  apb_rd;
	logic                  addr_ok;
	logic                  wr_key;
	logic                  wr_flags;
	logic                  wr_irq_stat;
	logic                  wr_irq_mask;

	// pready is registered: no wait state, read data from a flop
	assign apb_setup = psel_i & ~penable_i;
	assign apb_wr    = psel_i & penable_i & pwrite_i & pready_o;
	assign apb_rd    = apb_setup & ~pwrite_i;
	assign addr_ok = (paddr_i == SELECT_KEY_OFS) ||
		(paddr_i == CAUSE_FLAGS_OFS) || (paddr_i == FLASH_CTL1_OFS) ||
		(paddr_i == STATUS_OFS) || (paddr_i == IRQ_STAT_OFS) ||
		(paddr_i == IRQ_MASK_OFS);

	// writes land at the access edge, while pready is high
	assign wr_key      = apb_wr && (paddr_i == SELECT_KEY_OFS);
	assign wr_flags    = apb_wr && (paddr_i == CAUSE_FLAGS_OFS);
	assign wr_irq_stat = apb_wr && (paddr_i == IRQ_STAT_OFS);
	assign wr_irq_mask = apb_wr && (paddr_i == IRQ_MASK_OFS);

	// ****************************************
	// brownout qualifier and key check
	// ****************************************
	logic        bo_active;
	logic [31:0] qual_cnt;
	logic [31:0] key_cnt;
	logic        brownout_reset;
	logic        key_reset;
	logic        flash_reset;
	logic        wdt_normal;
	logic        wdt_lowpwr;
	logic        in_low_power;

	// detection gated off in idle, sleep, deep sleep
	assign in_low_power = low_power(power_mode_i, deep_sleep_i);
	assign bo_active    = brownout_enable_i & low_s &
		~in_low_power;

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			qual_cnt <= 32'h0;
		end else if (clk_en_i) begin
			if (!bo_active || brownout_reset) begin
				qual_cnt <= 32'h0;
			end else begin
				qual_cnt <= qual_cnt + 32'h1;
			end
		end
	end
	// fires only once the low level has outlasted the count
	assign brownout_reset = bo_active &&
		(qual_cnt >= 32'(QUALIFY_CNT));

	// ****************************************
	// threshold key watch
	// ****************************************
	// restarts whenever a valid pattern returns, so a fix in time is quiet
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			key_cnt <= 32'h0;
		end else if (clk_en_i) begin
			if (key_valid(select_key) || key_reset) begin
				key_cnt <= 32'h0;
			end else begin
				key_cnt <= key_cnt + 32'h1;
			end
		end
	end
	assign key_reset = !key_valid(select_key) &&
		(key_cnt >= 32'(SRESET_CNT));

	// ****************************************
	// reset events
	// ****************************************
	assign flash_reset = apb_wr && (paddr_i == FLASH_CTL1_OFS) &&
		(pwdata_i[7:0] == FLASH_RESET_KEY);
	assign wdt_normal = wdt_rise & ~in_low_power;
	assign wdt_lowpwr = wdt_rise & in_low_power;

	logic full_event;
	assign full_event = brownout_reset | key_reset | flash_reset |
		wdt_normal | wdk_rise | rsk_rise;

	// ****************************************
	// select key register
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			select_key <= KEY_POR;
		end else if (clk_en_i) begin
			if (key_reset) begin
				select_key <= KEY_POR;
			end else if (wr_key) begin
				select_key <= pwdata_i[7:0];
			end
			// brownout reset leaves the key untouched
		end
	end

	// ****************************************
	// cause flags: set wins over software clear
	// ****************************************
	logic [CAUSE_BITS-1:0] cause_set;
	always_comb begin
		cause_set = '0;
		cause_set[BROWNOUT_BIT] = brownout_reset;
		cause_set[KEY_CORR_BIT] = key_reset;
		cause_set[WDG_KEY_BIT]  = wdk_rise;
		cause_set[RST_KEY_BIT]  = rsk_rise;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			reset_cause_flags <= '0;
		end else if (clk_en_i) begin
			if (wr_flags) begin
				// software may only clear: writing one keeps a flag
				reset_cause_flags <= sticky(reset_cause_flags,
					pwdata_i[CAUSE_BITS-1:0], cause_set);
			end else begin
				reset_cause_flags <= sticky(reset_cause_flags, 4'hF,
					cause_set);
			end
		end
	end

	// ****************************************
	// expiry and powerdown flags
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			watchdog_expiry_flag <= 1'b0;
			powerdown_flag       <= 1'b0;
		end else if (clk_en_i) begin
			if (wdt_normal) begin
				watchdog_expiry_flag <= 1'b1;
			end else if (wdt_lowpwr) begin
				watchdog_expiry_flag <= 1'b1;
				powerdown_flag       <= 1'b1;
			end
			// brownout leaves both as they are
		end
	end

	// ****************************************
	// core reset pulse
	// ****************************************
	logic [2:0]  core_cnt;
	core_reset_t next_core;

	always_comb begin
		next_core = '0;
		if (srst_i || full_event) begin
			next_core = '1;
		end else if (wdt_lowpwr) begin
			next_core.pc_clear = 1'b1;
			next_core.sp_clear = 1'b1;
		end
	end

	// stretched so the core network sees a reset of several cycles
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			core_reset_o <= '1;
			core_cnt     <= 3'(CORE_RST_CYCLES);
		end else if (clk_en_i) begin
			if (next_core != '0) begin
				// a partial reset never cuts a full one short
				core_reset_o <= core_reset_o | next_core;
				core_cnt     <= 3'(CORE_RST_CYCLES);
			end else if (core_cnt != 3'h0) begin
				core_cnt <= core_cnt - 3'h1;
			end else begin
				core_reset_o <= '0;
			end
		end
	end

	// ****************************************
	// interrupt status and mask
	// ****************************************
	logic [IRQ_BITS-1:0] irq_set;
	always_comb begin
		irq_set = '0;
		irq_set[IRQ_BROWNOUT] = brownout_reset;
		irq_set[IRQ_KEY_CORR] = key_reset;
		irq_set[IRQ_WDG]      = wdt_rise;
		irq_set[IRQ_FLASH]    = flash_reset;
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			irq_stat <= '0;
			irq_mask <= '0;
		end else if (clk_en_i) begin
			if (wr_irq_stat) begin
				irq_stat <= sticky(irq_stat, ~pwdata_i[IRQ_BITS-1:0],
					irq_set);
			end else begin
				irq_stat <= sticky(irq_stat, 4'hF, irq_set);
			end
			if (wr_irq_mask) begin
				irq_mask <= pwdata_i[IRQ_BITS-1:0];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			irq_o <= 1'b0;
		end else if (clk_en_i) begin
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// ****************************************
	// read data mux
	// ****************************************
	logic [31:0] next_rdata;
	always_comb begin
		next_rdata = 32'h0;
		case (paddr_i)
			SELECT_KEY_OFS:  next_rdata = {24'h0, select_key};
			// upper nibble always zero
			CAUSE_FLAGS_OFS: next_rdata = {28'h0, reset_cause_flags};
			STATUS_OFS:      next_rdata = {30'h0, powerdown_flag,
				watchdog_expiry_flag};
			IRQ_STAT_OFS:    next_rdata = {28'h0, irq_stat};
			IRQ_MASK_OFS:    next_rdata = {28'h0, irq_mask};
			default:         next_rdata = 32'h0;
		endcase
	end

	// ****************************************
	// apb slave: no wait state, data ready with pready
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		if (srst_i) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= 32'h0;
		end else if (clk_en_i) begin
			pready_o  <= apb_setup;
			pslverr_o <= apb_setup & ~addr_ok;
			if (apb_rd) begin
				prdata_o <= next_rdata;
			end else if (!psel_i) begin
				prdata_o <= 32'h0;
			end
		end
	end

endmodule // brownout_and_reset_flags

// ==== hw/brownout_pkg.sv ====
// constants, register map and carrier types of the reset source block
// assumes one 125 MHz system clock and an apb master for software access
// Overview of operation
// - enabled low supply gives reset, cause flag
// - low supply must outlast qualify time
// - four valid threshold key patterns only
// - invalid key resets after delay, flag set
// - key corruption reset restores key power-on
// - brownout reset keeps key register contents
// - key powers on as 01010101
// - brownout detection off in low-power modes
// - bit 2 brownout flag, software clears
// - bit 1 key corrupt flag, software clears
// - flag bits 7 to 4 read zero
// - writing 55H to flash control resets
// - normal watchdog expiry resets, sets expiry
// - low-power expiry clears pc, sp only
// - expiry, powerdown flags follow reset cause
// - power-on reset initialises core state
package brownout_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] SELECT_KEY_OFS  = 12'h000;
	localparam logic [11:0] CAUSE_FLAGS_OFS = 12'h004;
	localparam logic [11:0] FLASH_CTL1_OFS  = 12'h008;
	localparam logic [11:0] STATUS_OFS      = 12'h00C;
	localparam logic [11:0] IRQ_STAT_OFS    = 12'h010;
	localparam logic [11:0] IRQ_MASK_OFS    = 12'h014;

	localparam logic [7:0] KEY_POR     = 8'h55;
	localparam logic [7:0] KEY_VALID_A = 8'h55;
	localparam logic [7:0] KEY_VALID_B = 8'h33;
	localparam logic [7:0] KEY_VALID_C = 8'h99;
	localparam logic [7:0] KEY_VALID_D = 8'hAA;
	localparam logic [7:0] FLASH_RESET_KEY = 8'h55;

	// cause flag bit positions
	localparam int WDG_KEY_BIT   = 0;
	localparam int KEY_CORR_BIT  = 1;
	localparam int BROWNOUT_BIT  = 2;
	localparam int RST_KEY_BIT   = 3;
	localparam int CAUSE_BITS    = 4;
	// status bit positions
	localparam int EXPIRY_BIT    = 0;
	localparam int POWERDOWN_BIT = 1;
	// irq event positions
	localparam int IRQ_BROWNOUT  = 0;
	localparam int IRQ_KEY_CORR  = 1;
	localparam int IRQ_WDG       = 2;
	localparam int IRQ_FLASH     = 3;
	localparam int IRQ_BITS      = 4;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ           = 125;
	localparam int QUALIFY_TIME_US   = 120;
	localparam int SRESET_TIME_US    = 45;
	localparam int QUALIFY_CYCLES    = QUALIFY_TIME_US * CLK_MHZ;
	localparam int SRESET_CYCLES     = SRESET_TIME_US * CLK_MHZ;
	localparam int CORE_RST_CYCLES   = 4;

	// ****************************************
	// carrier types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_SLOW   = 2'b01,
		MODE_IDLE   = 2'b10,
		MODE_SLEEP  = 2'b11
	} power_mode_t;

	typedef struct packed {
		logic pc_clear;
		logic sp_clear;
		logic irq_disable;
		logic wdt_clear;
		logic timers_off;
		logic ports_input;
		logic full_reset;
	} core_reset_t;

endpackage

// ==== test/brownout_and_reset_flags_tb.sv ====
// self-checking bench of the reset source block
// assumes supply_model as comparator and core reset network
module brownout_and_reset_flags_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import brownout_pkg::*;
	localparam int QC = 20;
	localparam int SC = 10;
	logic        ref_clk_i = 1'b0, srst_i = 1'b1, bo_en = 1'b1;
	logic        wdt_exp = 1'b0, wdt_key = 1'b0, rst_key = 1'b0;
	logic        deep = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        low, pready, pslverr, irq;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [15:0] drop = 16'h0;
	logic [7:0]  n_full, base, k;
	logic [7:0]  vk[4] = '{8'h55, 8'h33, 8'h99, 8'hAA};
	power_mode_t mode = MODE_NORMAL;
	core_reset_t core;
	logic [31:0] exp_q[$];
	int          n_mismatch = 0, samples_checked = 0, seed = 32'hC14B;
	brownout_and_reset_flags #(.QUALIFY_CNT(QC), .SRESET_CNT(SC))
		u_brownout_and_reset_flags (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
		.clk_en_i(1'b1), .brownout_enable_i(bo_en), .low_supply_i(low),
		.wdt_expiry_i(wdt_exp), .wdt_key_reset_i(wdt_key),
		.rst_key_reset_i(rst_key), .deep_sleep_i(deep), .power_mode_i(mode),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .core_reset_o(core),
		.irq_o(irq));
	supply_model u_supply_model (.ref_clk_i(ref_clk_i), .drop_i(drop),
		.core_reset_i(core), .low_supply_o(low), .full_cnt_o(n_full));
	always #4 ref_clk_i = ~ref_clk_i;
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		tick(1);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		tick(1);
		penable <= 1'b1;
		do tick(1); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		apb(1'b0, a, 32'h0);
	endtask
	task automatic sag(input int n);
		drop <= 16'(n);
		tick(2);
		drop <= 16'h0;
		tick(n + 20);
	endtask
	task automatic expire();
		wdt_exp <= 1'b1;
		tick(3);
		wdt_exp <= 1'b0;
		tick(12);
	endtask
	// read results are judged here, oldest note first
	always @(posedge ref_clk_i)
		if (psel && penable && pready === 1'b1) begin
			check(pslverr, {31'h0, paddr == 12'h018});
			if (!pwrite) check(prdata, exp_q.pop_front());
		end
	initial begin
		tick(20);
		srst_i <= 1'b0;
		tick(8);
		rd(SELECT_KEY_OFS, 32'h55);
		rd(CAUSE_FLAGS_OFS, 32'h0);
		rd(12'h018, 32'h0);
		base = n_full;
		foreach (vk[i]) begin
			apb(1'b1, SELECT_KEY_OFS, {24'h0, vk[i]});
			rd(SELECT_KEY_OFS, {24'h0, vk[i]});
		end
		tick(SC + 10);
		check(n_full, base);
		do k = 8'($random(seed)); while (k inside {8'h55, 8'h33, 8'h99, 8'hAA});
		apb(1'b1, SELECT_KEY_OFS, {24'h0, k});
		tick(SC + 12);
		check(n_full, base + 8'h01);
		rd(SELECT_KEY_OFS, 32'h55);
		apb(1'b1, CAUSE_FLAGS_OFS, 32'hFFFFFFFF);
		rd(CAUSE_FLAGS_OFS, 32'h2);
		apb(1'b1, CAUSE_FLAGS_OFS, 32'h0);
		rd(CAUSE_FLAGS_OFS, 32'h0);
		apb(1'b1, SELECT_KEY_OFS, 32'h33);
		base = n_full;
		sag(QC - 6);
		check(n_full, base);
		sag(QC + 14);
		check(n_full, base + 8'h01);
		rd(SELECT_KEY_OFS, 32'h33);
		rd(CAUSE_FLAGS_OFS, 32'h4);
		rd(STATUS_OFS, 32'h0);
		for (int i = 0; i < 4; i++) begin
			bo_en <= (i != 0);
			mode <= (i == 1) ? MODE_IDLE : (i == 3) ? MODE_SLEEP : MODE_NORMAL;
			deep <= (i == 2);
			sag(QC + 14);
			check(n_full, base + 8'h01);
		end
		bo_en <= 1'b1;
		mode <= MODE_NORMAL;
		deep <= 1'b0;
		expire();
		check(n_full, base + 8'h02);
		rd(STATUS_OFS, 32'h1);
		mode <= MODE_SLEEP;
		expire();
		check(n_full, base + 8'h02);
		rd(STATUS_OFS, 32'h3);
		mode <= MODE_NORMAL;
		wdt_key <= 1'b1;
		rst_key <= 1'b1;
		tick(1);
		wdt_key <= 1'b0;
		rst_key <= 1'b0;
		tick(4);
		rd(CAUSE_FLAGS_OFS, 32'hD);
		check(n_full, base + 8'h03);
		apb(1'b1, FLASH_CTL1_OFS, 32'h55);
		tick(10);
		check(n_full, base + 8'h04);
		check(irq, 1'b0);
		apb(1'b1, IRQ_MASK_OFS, 32'h8);
		tick(3);
		check(irq, 1'b1);
		apb(1'b1, IRQ_STAT_OFS, 32'h8);
		tick(3);
		check(irq, 1'b0);
		apb(1'b1, SELECT_KEY_OFS, 32'h99);
		srst_i <= 1'b1;
		tick(3);
		srst_i <= 1'b0;
		tick(8);
		rd(STATUS_OFS, 32'h0);
		rd(SELECT_KEY_OFS, 32'h55);
		tick(2);
		end_sim();
	end
	initial begin
		#100us;
		n_mismatch++;
		end_sim();
	end
endmodule // brownout_and_reset_flags_tb

// ==== test/brownout_asserts.sv ====
// port checker of the reset source block
// assumes it is bound onto brownout_and_reset_flags
module brownout_asserts #(
	parameter int QUALIFY_CNT = 20,
	parameter int SRESET_CNT  = 10
) (
	input wire logic                      ref_clk_i,
	input wire logic                      srst_i,
	input wire logic                      brownout_enable_i,
	input wire logic                      low_supply_i,
	input wire logic                      deep_sleep_i,
	input wire brownout_pkg::power_mode_t power_mode_i,
	input wire logic                      psel_i,
	input wire logic                      penable_i,
	input wire logic                      pwrite_i,
	input wire logic [11:0]               paddr_i,
	input wire logic [31:0]               pwdata_i,
	input wire logic [31:0]               prdata_o,
	input wire logic                      pready_o,
	input wire brownout_pkg::core_reset_t core_reset_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import brownout_pkg::*;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (srst_i);
	localparam int KEY_LO = SRESET_CNT - 1;
	localparam int KEY_HI = SRESET_CNT + 4;
	logic [15:0] lo_n;
	logic        hit;
	logic        lo_ok;
	logic        wr_ok;
	assign lo_ok = low_supply_i && brownout_enable_i && !deep_sleep_i
		&& power_mode_i < MODE_IDLE;
	assign wr_ok = psel_i && penable_i && pready_o && pwrite_i;
	// ****************
	// low run length, sync lag hidden in the margin
	// ****************
	always_ff @(posedge ref_clk_i) begin
		lo_n <= (srst_i || !lo_ok) ? 16'h0000 : lo_n + 16'h0001;
		hit  <= !srst_i && lo_ok && (hit || core_reset_o.full_reset);
	end
	chk_ready_next:
	assert property (psel_i && !penable_i |=> pready_o) else $error("ready");
	chk_ready_single:
	assert property (pready_o |=> !pready_o) else $error("ready held");
	chk_flag_upper:
	assert property (pready_o && !pwrite_i && paddr_i == CAUSE_FLAGS_OFS
		|-> prdata_o[31:4] == 28'h0) else $error("flag upper bits");
	chk_flash_reset:
	assert property (wr_ok && paddr_i == FLASH_CTL1_OFS
		&& pwdata_i[7:0] == 8'h55 |-> ##[1:3] core_reset_o.full_reset)
		else $error("flash reset");
	chk_key_reset:
	assert property (wr_ok && paddr_i == SELECT_KEY_OFS && !(pwdata_i[7:0]
		inside {8'h55, 8'h33, 8'h99, 8'hAA})
		|-> ##[KEY_LO:KEY_HI] core_reset_o.full_reset) else $error("key");
	chk_full_all:
	assert property (core_reset_o.full_reset |-> core_reset_o == 7'h7F)
		else $error("full reset parts");
	chk_sleep_wdg:
	assert property (core_reset_o.pc_clear && !core_reset_o.full_reset
		|-> core_reset_o == 7'h60) else $error("low power expiry");
	chk_brownout_fire:
	assert property (lo_n == QUALIFY_CNT + 10 |-> hit) else $error("brownout");
endmodule // brownout_asserts

bind brownout_and_reset_flags brownout_asserts #(.QUALIFY_CNT(QUALIFY_CNT),
	.SRESET_CNT(SRESET_CNT)) u_brownout_asserts (.ref_clk_i(ref_clk_i),
	.srst_i(srst_i), .brownout_enable_i(brownout_enable_i),
	.low_supply_i(low_supply_i), .deep_sleep_i(deep_sleep_i),
	.power_mode_i(power_mode_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .core_reset_o(core_reset_o));

// ==== test/supply_model.sv ====
// supply comparator and core reset network of the far side
// assumes the bench asks for a sag by a nonzero length on drop_i
module supply_model (
	input  wire logic                      ref_clk_i,
	input  wire logic [15:0]               drop_i,
	input  wire brownout_pkg::core_reset_t core_reset_i,
	output logic                           low_supply_o,
	output logic [7:0]                     full_cnt_o
);
	timeunit 1ns;
	timeprecision 1ps;
	import brownout_pkg::*;
	initial begin
		low_supply_o = 1'b0;
		full_cnt_o = 8'h00;
	end
	// edges land off the clock: the comparator is asynchronous
	always @(drop_i) if (drop_i != 16'h0000) begin
		#3 low_supply_o = 1'b1;
		repeat (drop_i) @(posedge ref_clk_i);
		#3 low_supply_o = 1'b0;
	end
	always @(posedge core_reset_i.full_reset) full_cnt_o <= full_cnt_o + 8'h01;
endmodule // supply_model
